// ---- include/dcss_map.vh ----
// Purpose: constants for the deflection control switches and status block
// Assumes: included once per design file by bare name
// Notes: subaddresses, bit positions, defaults and bus addresses
`ifndef DCSS_MAP_VH
`define DCSS_MAP_VH
`define DCSS_WR_ADDR 8'h8c
`define DCSS_RD_ADDR 8'h8d
`define DCSS_SUB_HDUTY 8'h00
`define DCSS_SUB_BREF 8'h03
`define DCSS_SUB_BPH 8'h07
`define DCSS_SUB_DYN 8'h15
`define DCSS_SUB_SW16 8'h16
`define DCSS_SUB_SW17 8'h17
`define DCSS_ALIGN_BIT 7
`define DCSS_LOCK_EN_BIT 0
`define DCSS_INH_EN_BIT 1
`define DCSS_PUMP_BIT 2
`define DCSS_MOIRE_BIT 3
`define DCSS_DET_CLR_BIT 4
`define DCSS_SRC_SEL_BIT 5
`define DCSS_SRC_AUTO_BIT 6
`define DCSS_ALARM_CLR_BIT 7
`define DCSS_BLANK_BIT 0
`define DCSS_VERT_RAMP_OUT_EN_BIT 1
`define DCSS_HB_EN_BIT 2
`define DCSS_EDGE_BIT 3
`define DCSS_RST_DATA 8'h00
`define DCSS_RST_SW16 8'h43
`define DCSS_RST_SW17 8'h01
`define DCSS_CLK_NS 10
`define DCSS_SOFT_NS 100000
`define DCSS_BPLUS_NS 500
`endif

// ---- src/dcss_top.v ----
// Purpose: switch registers, status byte and serial slave of the deflection control
// Assumes: all pin inputs asynchronous to SYS_CLK_I; serial clock far below system clock
// Notes: analog waveforms are outside; this block steers them with digital controls
`timescale 1ns/100ps
`include "dcss_map.vh"

module dcss_top #(
	parameter SOFT_CYC = `DCSS_SOFT_NS / `DCSS_CLK_NS,
	parameter POL_W = 8
) (
	input wire SYS_CLK_I,
	input wire RESET_N_I,
	input wire SCL_I,
	input wire SDA_I,
	input wire VERT_SYNC_IN_I,
	input wire COMPOSITE_SYNC_IN_I,
	input wire EXTRACTED_VSYNC_I,
	input wire VERT_DISCHARGE_I,
	input wire FLYBACK_I,
	input wire HORIZ_TIMEBASE_I,
	input wire MOIRE_I,
	input wire OVERVOLT_I,
	input wire VERT_AMP_UNLOCKED_I,
	input wire HORIZ_LOOP_UNLOCKED_I,
	input wire SUPPLY_OK_I,
	input wire EXT_SAWTOOTH_I,
	output reg SDA_O,
	output reg SDA_OE_O,
	output reg HORIZ_DRIVE_OUT_O,
	output reg BPLUS_DRIVE_OUT_O,
	output reg VERT_RAMP_ENABLE_O,
	output reg LOCK_BLANK_PIN_O,
	output reg LOOP_INHIBIT_O,
	output reg LOOP_PUMP_CURRENT_O,
	output reg MOIRE_OUT_O,
	output reg DYN_CORR_POLARITY_O,
	output reg VERT_SOURCE_O,
	output reg HORIZ_SOFT_START_O,
	output reg BPLUS_SOFT_START_O,
	output reg [6:0] HORIZ_DUTY_O,
	output reg [6:0] BPLUS_REF_O
);

	localparam BPLUS_CYC = (`DCSS_BPLUS_NS + `DCSS_CLK_NS - 1) / `DCSS_CLK_NS;
	localparam ST_IDLE = 5'b00001;
	localparam ST_RX = 5'b00010;
	localparam ST_ACK = 5'b00100;
	localparam ST_TX = 5'b01000;
	localparam ST_TXACK = 5'b10000;

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	reg [14:0] in_s1;
	reg [14:0] in_s2;
	reg [14:0] in_d;
	wire [14:0] pins_in;

	assign pins_in = {EXT_SAWTOOTH_I, SUPPLY_OK_I, HORIZ_LOOP_UNLOCKED_I, VERT_AMP_UNLOCKED_I,
		OVERVOLT_I, MOIRE_I, HORIZ_TIMEBASE_I, FLYBACK_I, VERT_DISCHARGE_I,
		EXTRACTED_VSYNC_I, COMPOSITE_SYNC_IN_I, VERT_SYNC_IN_I, SDA_I, SCL_I, 1'b0};

	// two stages, then one more stage for edge finding
	always @(posedge SYS_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			in_s1 <= 15'h0000;
			in_s2 <= 15'h0000;
			in_d <= 15'h0000;
		end
		else
		begin
			in_s1 <= pins_in;
			in_s2 <= in_s1;
			in_d <= in_s2;
		end
	end

	wire scl = in_s2[1];
	wire sda = in_s2[2];
	wire vert_sync_in = in_s2[3];
	wire comp = in_s2[4];
	wire extr = in_s2[5];
	wire disch = in_s2[6];
	wire hdrv = in_s2[8];
	wire moire = in_s2[9];
	wire xray = in_s2[10];
	wire supply = in_s2[13];
	wire [14:0] rise = in_s2 & ~in_d;
	wire [14:0] fall = ~in_s2 & in_d;
	wire i2c_start = scl & in_d[1] & in_d[2] & ~sda;
	wire i2c_stop = scl & in_d[1] & ~in_d[2] & sda;

	// saturating up/down count toward the dominant level
	function [POL_W-1:0] pol_step;
		input [POL_W-1:0] cnt;
		input up;
		begin
			if (up)
				pol_step = (&cnt) ? cnt : cnt + 1'b1;
			else
				pol_step = (|cnt) ? cnt - 1'b1 : cnt;
		end
	endfunction

	// ---------------------------------------------------------------
	// serial slave
	// ---------------------------------------------------------------
	reg [4:0] state;
	reg [3:0] bitc;
	reg [7:0] shreg;
	reg [7:0] tx;
	reg [1:0] bytec;
	reg rd_mode;
	reg [7:0] sub;
	reg wr_stb;
	reg [7:0] wr_sub;
	reg [7:0] wr_data;
	wire [7:0] status;

	// start and stop win over any state; no answer without supply
	always @(posedge SYS_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			state <= ST_IDLE;
			bitc <= 4'h0;
			shreg <= 8'h00;
			tx <= 8'h00;
			bytec <= 2'h0;
			rd_mode <= 1'b0;
			sub <= 8'h00;
			wr_stb <= 1'b0;
			wr_sub <= 8'h00;
			wr_data <= 8'h00;
			SDA_O <= 1'b0;
			SDA_OE_O <= 1'b0;
		end
		else
		begin
			wr_stb <= 1'b0;
			SDA_O <= 1'b0;
			if (!supply)
			begin
				state <= ST_IDLE;
				SDA_OE_O <= 1'b0;
			end
			else if (i2c_start)
			begin
				state <= ST_RX;
				bitc <= 4'h0;
				bytec <= 2'h0;
				SDA_OE_O <= 1'b0;
			end
			else if (i2c_stop)
			begin
				state <= ST_IDLE;
				SDA_OE_O <= 1'b0;
			end
			else
			begin
				case (state)
				ST_RX:
				begin
					if (rise[1] && bitc != 4'h8)
					begin
						shreg <= {shreg[6:0], sda};
						bitc <= bitc + 4'h1;
					end
					else if (fall[1] && bitc == 4'h8)
					begin
						state <= ST_ACK;
						SDA_OE_O <= 1'b1;
						if (bytec == 2'h0)
						begin
							rd_mode <= shreg[0];
							if (shreg != `DCSS_WR_ADDR && shreg != `DCSS_RD_ADDR)
							begin
								state <= ST_IDLE;
								SDA_OE_O <= 1'b0;
							end
						end
						else if (bytec == 2'h1)
							sub <= shreg;
						else
						begin
							wr_stb <= 1'b1; // commit at the acknowledge
							wr_sub <= sub;
							wr_data <= shreg;
							sub <= sub + 8'h01;
						end
					end
				end
				ST_ACK:
				begin
					if (fall[1])
					begin
						bytec <= (bytec == 2'h2) ? bytec : bytec + 2'h1;
						bitc <= 4'h0;
						SDA_OE_O <= 1'b0;
						state <= ST_RX;
						if (rd_mode && bytec == 2'h0)
						begin
							state <= ST_TX;
							tx <= {status[6:0], 1'b0};
							SDA_OE_O <= ~status[7];
							bitc <= 4'h1;
						end
					end
				end
				ST_TX:
				begin
					if (fall[1])
					begin
						if (bitc == 4'h8)
						begin
							SDA_OE_O <= 1'b0;
							state <= ST_TXACK;
						end
						else
						begin
							SDA_OE_O <= ~tx[7];
							tx <= {tx[6:0], 1'b0};
							bitc <= bitc + 4'h1;
						end
					end
				end
				ST_TXACK:
				begin
					// master nak ends the read; ack repeats the status byte
					if (rise[1] && sda)
						state <= ST_IDLE;
					else if (fall[1])
					begin
						state <= ST_TX;
						tx <= {status[6:0], 1'b0};
						SDA_OE_O <= ~status[7];
						bitc <= 4'h1;
					end
				end
				default:
					state <= ST_IDLE;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// control registers, write-only
	// ---------------------------------------------------------------
	reg [7:0] duty_reg;
	reg [7:0] bref_reg;
	reg bplus_phase_select;
	reg dyn_corr_polarity;
	reg [7:0] sw16;
	reg [7:0] sw17;
	wire wr16 = wr_stb && wr_sub == `DCSS_SUB_SW16;
	wire detect_flags_clear = wr16 && wr_data[`DCSS_DET_CLR_BIT];
	wire overvolt_alarm_clear = wr16 && wr_data[`DCSS_ALARM_CLR_BIT];

	// clear bits are never stored, so they stay zero in sw16 after the write
	always @(posedge SYS_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			duty_reg <= `DCSS_RST_DATA;
			bref_reg <= `DCSS_RST_DATA;
			bplus_phase_select <= 1'b0;
			dyn_corr_polarity <= 1'b0;
			sw16 <= `DCSS_RST_SW16;
			sw17 <= `DCSS_RST_SW17;
		end
		else if (!supply)
		begin
			duty_reg <= `DCSS_RST_DATA;
			bref_reg <= `DCSS_RST_DATA;
			bplus_phase_select <= 1'b0;
			dyn_corr_polarity <= 1'b0;
			sw16 <= `DCSS_RST_SW16;
			sw17 <= `DCSS_RST_SW17;
		end
		else if (wr_stb)
		begin
			case (wr_sub)
			`DCSS_SUB_HDUTY: duty_reg <= wr_data;
			`DCSS_SUB_BREF: bref_reg <= wr_data;
			`DCSS_SUB_BPH: bplus_phase_select <= wr_data[7];
			`DCSS_SUB_DYN: dyn_corr_polarity <= wr_data[7];
			`DCSS_SUB_SW16: sw16 <= wr_data & 8'h6f;
			`DCSS_SUB_SW17: sw17 <= wr_data;
			default: sw17 <= sw17;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// status flags and source selection
	// ---------------------------------------------------------------
	reg vert_input_seen;
	reg composite_input_seen;
	reg extracted_vert_seen;
	reg overvolt_alarm;
	reg [POL_W-1:0] vert_input_polarity_cnt;
	reg [POL_W-1:0] cpol_cnt;
	wire vert_source_auto = sw16[`DCSS_SRC_AUTO_BIT];

	assign status = {in_s2[12], in_s2[11], overvolt_alarm, cpol_cnt[POL_W-1],
		vert_input_polarity_cnt[POL_W-1], extracted_vert_seen, composite_input_seen, vert_input_seen};

	// set wins over clear so a pulse in the clear cycle is kept
	always @(posedge SYS_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			vert_input_seen <= 1'b0;
			composite_input_seen <= 1'b0;
			extracted_vert_seen <= 1'b0;
			overvolt_alarm <= 1'b0;
			vert_input_polarity_cnt <= {POL_W{1'b0}};
			cpol_cnt <= {POL_W{1'b0}};
			VERT_SOURCE_O <= 1'b0;
		end
		else
		begin
			vert_input_seen <= rise[3] | (vert_input_seen & ~detect_flags_clear);
			composite_input_seen <= rise[4] | (composite_input_seen & ~detect_flags_clear);
			extracted_vert_seen <= rise[5] | (extracted_vert_seen & ~detect_flags_clear);
			overvolt_alarm <= xray | (overvolt_alarm & ~overvolt_alarm_clear);
			vert_input_polarity_cnt <= pol_step(vert_input_polarity_cnt, vert_sync_in);
			cpol_cnt <= pol_step(cpol_cnt, comp);
			if (!vert_source_auto)
				VERT_SOURCE_O <= sw16[`DCSS_SRC_SEL_BIT];
			else if (VERT_SOURCE_O && !vert_input_seen && extracted_vert_seen)
				VERT_SOURCE_O <= 1'b0;
			else if (!VERT_SOURCE_O && !extracted_vert_seen && vert_input_seen)
				VERT_SOURCE_O <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// drives, blanking and timed updates
	// ---------------------------------------------------------------
	reg blank;
	reg hb_en_d;
	reg [7:0] bcnt;
	reg [31:0] ss_cnt;
	wire hb_en = sw17[`DCSS_HB_EN_BIT] & supply;
	wire drive_run = hb_en & ~overvolt_alarm;
	wire vsel_rise = VERT_SOURCE_O ? rise[3] : rise[5];
	wire moire_internal = ~sw16[`DCSS_MOIRE_BIT];
	wire hdrv_mod = (moire_internal & moire) ? in_d[8] : hdrv;
	wire edge_hit = sw17[`DCSS_EDGE_BIT] ? rise[8] : fall[8];
	wire bplus_start = bplus_phase_select ? edge_hit : fall[7];
	wire ss_go = hb_en & ~hb_en_d;

	// delayed data moves only on discharge when aligned
	always @(posedge SYS_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			HORIZ_DUTY_O <= 7'h00;
			BPLUS_REF_O <= 7'h00;
		end
		else
		begin
			// immediate data comes from the strobe, the stored byte lands one cycle later
			if (!supply)
				HORIZ_DUTY_O <= 7'h00;
			else if (wr_stb && wr_sub == `DCSS_SUB_HDUTY && !wr_data[`DCSS_ALIGN_BIT])
				HORIZ_DUTY_O <= wr_data[6:0];
			else if (rise[6] && duty_reg[`DCSS_ALIGN_BIT])
				HORIZ_DUTY_O <= duty_reg[6:0];
			if (!supply)
				BPLUS_REF_O <= 7'h00;
			else if (wr_stb && wr_sub == `DCSS_SUB_BREF && !wr_data[`DCSS_ALIGN_BIT])
				BPLUS_REF_O <= wr_data[6:0];
			else if (rise[6] && bref_reg[`DCSS_ALIGN_BIT])
				BPLUS_REF_O <= bref_reg[6:0];
		end
	end

	// write strobe data is one cycle ahead of the stored byte, hence wr_data above
	always @(posedge SYS_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			blank <= 1'b0;
			hb_en_d <= 1'b0;
			bcnt <= 8'h00;
			ss_cnt <= 32'h0;
			HORIZ_DRIVE_OUT_O <= 1'b1;
			BPLUS_DRIVE_OUT_O <= 1'b0;
			VERT_RAMP_ENABLE_O <= 1'b0;
			LOCK_BLANK_PIN_O <= 1'b0;
			LOOP_INHIBIT_O <= 1'b0;
			LOOP_PUMP_CURRENT_O <= 1'b0;
			MOIRE_OUT_O <= 1'b0;
			DYN_CORR_POLARITY_O <= 1'b0;
			HORIZ_SOFT_START_O <= 1'b0;
			BPLUS_SOFT_START_O <= 1'b0;
		end
		else
		begin
			if (sw17[`DCSS_BLANK_BIT])
				blank <= 1'b1;
			else if (vsel_rise)
				blank <= 1'b1;
			else if (fall[6])
				blank <= 1'b0;
			LOCK_BLANK_PIN_O <= blank | (sw16[`DCSS_LOCK_EN_BIT] & in_s2[12]);
			LOOP_INHIBIT_O <= sw16[`DCSS_INH_EN_BIT] & extr;
			LOOP_PUMP_CURRENT_O <= sw16[`DCSS_PUMP_BIT];
			MOIRE_OUT_O <= ~moire_internal & moire;
			DYN_CORR_POLARITY_O <= dyn_corr_polarity;
			VERT_RAMP_ENABLE_O <= sw17[`DCSS_VERT_RAMP_OUT_EN_BIT] & supply;
			HORIZ_DRIVE_OUT_O <= drive_run ? hdrv_mod : 1'b1;
			// fixed-width B+ pulse from the chosen start event
			if (!hb_en)
				bcnt <= 8'h00;
			else if (bplus_start)
				bcnt <= BPLUS_CYC[7:0];
			else if (bcnt != 8'h00)
				bcnt <= bcnt - 8'h01;
			BPLUS_DRIVE_OUT_O <= hb_en & (bcnt != 8'h00);
			hb_en_d <= hb_en;
			if (ss_go)
				ss_cnt <= SOFT_CYC;
			else if (ss_cnt != 32'h0)
				ss_cnt <= ss_cnt - 32'h1;
			HORIZ_SOFT_START_O <= ss_cnt != 32'h0;
			BPLUS_SOFT_START_O <= (ss_cnt != 32'h0) & in_s2[14];
		end
	end

endmodule

// ---- sim/dcss_checker.sv ----
// Purpose: port-level checks of the deflection control block
// Assumes: SOFT_CYC matches the instance it is bound to
// Notes: latency windows allow for the two-flop input synchronisers
`timescale 1ns/100ps
module dcss_checker #(
	parameter SOFT_CYC = 20
) (
	input wire SYS_CLK_I,
	input wire RESET_N_I,
	input wire SCL_I,
	input wire EXTRACTED_VSYNC_I,
	input wire MOIRE_I,
	input wire OVERVOLT_I,
	input wire SUPPLY_OK_I,
	input wire SDA_OE_O,
	input wire HORIZ_DRIVE_OUT_O,
	input wire BPLUS_DRIVE_OUT_O,
	input wire VERT_RAMP_ENABLE_O,
	input wire LOOP_INHIBIT_O,
	input wire MOIRE_OUT_O,
	input wire HORIZ_SOFT_START_O
);
	localparam int BP_CYC = 50;
	reg [15:0] soft_cnt;
	reg [7:0] bp_cnt;
	// ---------------------------------------------
	// run lengths, judged when the pulse falls
	// ---------------------------------------------
	always @(posedge SYS_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			soft_cnt <= 16'h0000;
			bp_cnt <= 8'h00;
		end
		else
		begin
			soft_cnt <= HORIZ_SOFT_START_O ? soft_cnt + 16'h0001 : 16'h0000;
			bp_cnt <= BPLUS_DRIVE_OUT_O ? bp_cnt + 8'h01 : 8'h00;
		end
	end
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	drive_off_a: assert property (!SUPPLY_OK_I [*5] |->
		HORIZ_DRIVE_OUT_O && !BPLUS_DRIVE_OUT_O && !VERT_RAMP_ENABLE_O)
		else $error("drives left on without supply");
	no_ack_a: assert property (!SUPPLY_OK_I [*6] |-> !SDA_OE_O)
		else $error("data line pulled without supply");
	alarm_inhibit_a: assert property (OVERVOLT_I [*6] |-> HORIZ_DRIVE_OUT_O)
		else $error("horizontal drive runs during overvoltage");
	soft_len_a: assert property ($fell(HORIZ_SOFT_START_O) |->
		soft_cnt >= SOFT_CYC - 1 && soft_cnt <= SOFT_CYC + 1)
		else $error("soft start length wrong");
	bplus_width_a: assert property ($fell(BPLUS_DRIVE_OUT_O) |-> bp_cnt == BP_CYC)
		else $error("B+ pulse width wrong");
	ack_low_a: assert property ($changed(SDA_OE_O) |-> !SCL_I)
		else $error("data line moved while clock high");
	inhibit_cause_a: assert property (LOOP_INHIBIT_O |-> $past(EXTRACTED_VSYNC_I, 2)
		|| $past(EXTRACTED_VSYNC_I, 3) || $past(EXTRACTED_VSYNC_I, 4))
		else $error("loop inhibited without vertical pulse");
	moire_cause_a: assert property (MOIRE_OUT_O |-> $past(MOIRE_I, 2)
		|| $past(MOIRE_I, 3) || $past(MOIRE_I, 4))
		else $error("moire output without moire input");
endmodule
bind dcss_top dcss_checker #(.SOFT_CYC(SOFT_CYC)) u_chk (.SYS_CLK_I(SYS_CLK_I),
	.RESET_N_I(RESET_N_I), .SCL_I(SCL_I), .EXTRACTED_VSYNC_I(EXTRACTED_VSYNC_I),
	.MOIRE_I(MOIRE_I), .OVERVOLT_I(OVERVOLT_I), .SUPPLY_OK_I(SUPPLY_OK_I),
	.SDA_OE_O(SDA_OE_O), .HORIZ_DRIVE_OUT_O(HORIZ_DRIVE_OUT_O),
	.BPLUS_DRIVE_OUT_O(BPLUS_DRIVE_OUT_O), .VERT_RAMP_ENABLE_O(VERT_RAMP_ENABLE_O),
	.LOOP_INHIBIT_O(LOOP_INHIBIT_O), .MOIRE_OUT_O(MOIRE_OUT_O),
	.HORIZ_SOFT_START_O(HORIZ_SOFT_START_O));

// ---- sim/dcss_i2c_master.sv ----
// Purpose: serial bus master standing in for the controlling microcontroller
// Assumes: 4 system clocks per clock half, an 80 ns serial clock period
// Notes: clock idles high between frames; released data reads the pull-up
`timescale 1ns/100ps
module dcss_i2c_master (
	input wire clk_i,
	input wire sda_i,
	output reg scl_o,
	output reg sda_o
);
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic w(input integer n);
		repeat (n) @(posedge clk_i);
	endtask
	// ---------------------------------------------
	// framing; start also serves as repeated start
	// ---------------------------------------------
	task start;
	begin
		sda_o <= 1'b1;
		w(2);
		scl_o <= 1'b1;
		w(2);
		sda_o <= 1'b0;
		w(2);
		scl_o <= 1'b0;
		w(2);
	end
	endtask
	task stop;
	begin
		sda_o <= 1'b0;
		w(2);
		scl_o <= 1'b1;
		w(2);
		sda_o <= 1'b1;
		w(2);
	end
	endtask
	// nine bits msb first, the last one is the acknowledge slot
	task xfer(input [8:0] tx, output [8:0] rx);
		integer i;
		begin
			for (i = 8; i >= 0; i = i - 1)
			begin
				sda_o <= tx[i];
				w(2);
				scl_o <= 1'b1;
				w(2);
				rx[i] = sda_i;
				w(2);
				scl_o <= 1'b0;
				w(2);
			end
		end
	endtask
endmodule

// ---- sim/deflection_control_switches_and_status_tb.sv ----
// Purpose: self-checking bench of the deflection control switches and status
// Assumes: short soft start and polarity counters through the parameters
// Notes: line timebase is a 200-cycle period made here, drive high below 100
`timescale 1ns/100ps
`include "dcss_map.vh"
module deflection_control_switches_and_status_tb;
	reg clk;
	reg rst_n;
	reg supply;
	reg moire;
	reg h_unl;
	reg v_unl;
	reg htb;
	reg fly;
	reg [4:0] ev;
	reg [7:0] tb_cnt;
	reg [7:0] v;
	integer errors;
	integer num_checks;
	wire scl;
	wire sda_m;
	wire oe;
	wire sda;
	wire hdrv, bdrv, vramp, lbk, inh, pump, moi, dyn, vsrc;
	wire [6:0] duty;
	wire [6:0] bref;
	// open-drain line with pull-up
	assign sda = sda_m & ~oe;
	dcss_i2c_master m (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
	dcss_top #(.SOFT_CYC(20), .POL_W(4)) u_dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n),
		.SCL_I(scl), .SDA_I(sda), .VERT_SYNC_IN_I(ev[4]), .COMPOSITE_SYNC_IN_I(ev[3]),
		.EXTRACTED_VSYNC_I(ev[2]), .VERT_DISCHARGE_I(ev[1]), .FLYBACK_I(fly),
		.HORIZ_TIMEBASE_I(htb), .MOIRE_I(moire), .OVERVOLT_I(ev[0]),
		.VERT_AMP_UNLOCKED_I(v_unl), .HORIZ_LOOP_UNLOCKED_I(h_unl), .SUPPLY_OK_I(supply),
		.EXT_SAWTOOTH_I(1'b1), .SDA_O(), .SDA_OE_O(oe), .HORIZ_DRIVE_OUT_O(hdrv),
		.BPLUS_DRIVE_OUT_O(bdrv), .VERT_RAMP_ENABLE_O(vramp), .LOCK_BLANK_PIN_O(lbk),
		.LOOP_INHIBIT_O(inh), .LOOP_PUMP_CURRENT_O(pump), .MOIRE_OUT_O(moi),
		.DYN_CORR_POLARITY_O(dyn), .VERT_SOURCE_O(vsrc), .HORIZ_SOFT_START_O(),
		.BPLUS_SOFT_START_O(), .HORIZ_DUTY_O(duty), .BPLUS_REF_O(bref));
	always #5 clk = ~clk;
	// line timebase with flyback at the end of each period
	always @(posedge clk)
	begin
		tb_cnt <= (tb_cnt == 8'hc7) ? 8'h00 : tb_cnt + 8'h01;
		htb <= tb_cnt < 8'h64;
		fly <= tb_cnt >= 8'hb4;
	end
	// ---------------------------------------------
	// shared helpers
	// ---------------------------------------------
	task automatic cyc(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task at_low;
		while (tb_cnt !== 8'h96) @(posedge clk);
	endtask
	task chk(input [7:0] got, input [7:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			errors = errors + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task chk_b(input got, input exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask
	task pulse(input [4:0] p);
	begin
		ev <= p;
		cyc(10);
		ev <= 5'h00;
		cyc(10);
	end
	endtask
	task wr(input [7:0] sub, input [7:0] a, input [7:0] b, input two);
		reg [8:0] r;
		begin
			m.start;
			m.xfer({`DCSS_WR_ADDR, 1'b1}, r);
			chk_b(r[0], 1'b0);
			m.xfer({sub, 1'b1}, r);
			m.xfer({a, 1'b1}, r);
			chk_b(r[0], 1'b0);
			if (two)
				m.xfer({b, 1'b1}, r);
			m.stop;
		end
	endtask
	task rd(output [7:0] d);
		reg [8:0] r;
		begin
			m.start;
			m.xfer({`DCSS_RD_ADDR, 1'b1}, r);
			chk_b(r[0], 1'b0);
			m.xfer(9'h1ff, r);
			d = r[8:1];
			m.stop;
		end
	endtask
	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	task t_defaults;
	begin
		at_low;
		chk_b(hdrv, 1'b1);
		chk_b(bdrv, 1'b0);
		chk_b(vramp, 1'b0);
		chk_b(lbk, 1'b1);
		chk_b(pump, 1'b0);
	end
	endtask
	task t_switches;
	begin
		wr(`DCSS_SUB_SW16, 8'h2e, 8'h06, 1'b1);
		chk_b(pump, 1'b1);
		chk_b(vsrc, 1'b1);
		chk_b(vramp, 1'b1);
		at_low;
		chk_b(hdrv, 1'b0);
		moire <= 1'b1;
		cyc(6);
		chk_b(moi, 1'b1);
		moire <= 1'b0;
		cyc(6);
		chk_b(moi, 1'b0);
		wr(`DCSS_SUB_DYN, 8'h80, 8'h00, 1'b0);
		chk_b(dyn, 1'b1);
		ev <= 5'h04;
		cyc(6);
		chk_b(inh, 1'b1);
		ev <= 5'h00;
		cyc(6);
		chk_b(inh, 1'b0);
	end
	endtask
	task t_duty;
	begin
		wr(`DCSS_SUB_HDUTY, 8'h55, 8'h00, 1'b0);
		chk({1'b0, duty}, 8'h55);
		wr(`DCSS_SUB_BREF, 8'haa, 8'h00, 1'b0);
		chk({1'b0, bref}, 8'h00);
		pulse(5'h02);
		chk({1'b0, bref}, 8'h2a);
	end
	endtask
	task t_flags;
	begin
		wr(`DCSS_SUB_SW16, 8'hbe, 8'h00, 1'b0);
		h_unl <= 1'b1;
		v_unl <= 1'b1;
		pulse(5'h10);
		chk_b(lbk, 1'b1);
		pulse(5'h02);
		chk_b(lbk, 1'b0);
		pulse(5'h0d);
		at_low;
		chk_b(hdrv, 1'b1);
		rd(v);
		chk(v, 8'he7);
		ev <= 5'h10;
		cyc(20);
		wr(`DCSS_SUB_SW16, 8'hbe, 8'h00, 1'b0);
		cyc(20);
		rd(v);
		chk(v, 8'hc8);
		ev <= 5'h00;
		at_low;
		chk_b(hdrv, 1'b0);
	end
	endtask
	// automatic source: extracted seen first, then separate must not take over
	task t_auto;
	begin
		wr(`DCSS_SUB_SW16, 8'h70, 8'h00, 1'b0);
		pulse(5'h04);
		chk_b(vsrc, 1'b0);
		pulse(5'h10);
		chk_b(vsrc, 1'b0);
	end
	endtask
	task t_refuse;
		reg [8:0] r;
		begin
			m.start;
			m.xfer(9'h11d, r);
			chk_b(r[0], 1'b1);
			m.stop;
			@(negedge bdrv);
			@(posedge clk);
			supply <= 1'b0;
			cyc(8);
			chk_b(hdrv, 1'b1);
			chk_b(bdrv, 1'b0);
			chk_b(vramp, 1'b0);
			m.start;
			m.xfer({`DCSS_WR_ADDR, 1'b1}, r);
			chk_b(r[0], 1'b1);
			m.stop;
			supply <= 1'b1;
			cyc(8);
			chk_b(lbk, 1'b1);
		end
	endtask
	task report_and_stop;
	begin
		if (errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	// main sequence
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		supply = 1'b1;
		moire = 1'b0;
		h_unl = 1'b0;
		v_unl = 1'b0;
		htb = 1'b0;
		fly = 1'b0;
		ev = 5'h00;
		tb_cnt = 8'h00;
		errors = 0;
		num_checks = 0;
		cyc(2);
		rst_n <= 1'b1;
		t_defaults;
		t_switches;
		t_duty;
		t_flags;
		t_auto;
		t_refuse;
		report_and_stop;
	end
	// watchdog, well beyond the expected run length
	initial
	begin
		repeat (50000) @(posedge clk);
		errors = errors + 1;
		report_and_stop;
	end
endmodule
